// >>> design/uei_top.sv
`include "uei_map.svh"

module uei_top #(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cts_n,
    input wire uei_pkg::uei_evt_in_t evt_in,
    output uei_pkg::uei_task_t task_out,
    output logic irq
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    // previous flow-control level
    logic cts_prev;
    // sticky event flags
    uei_pkg::uei_vec_t evt;
    // interrupt enables (the mask)
    uei_pkg::uei_vec_t inten;
    // shortcut bits
    logic [1:0] shortcut;
    // raw event pulses this cycle
    uei_pkg::uei_vec_t evt_hit;
    // flow-control edges
    logic cts_fall;
    logic cts_rise;
    // bus phases
    logic acc;
    logic wr;
    logic setup_rd;
    // address decode
    logic mapped;
    logic [2:0] evt_idx;
    logic evt_sel;
    // read mux result
    logic [31:0] next_prdata;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // map an event register offset to its bit
    function automatic logic [3:0] evt_decode(
        input logic [11:0] a
    );
        logic [3:0] r;
        r = 4'h0;
        case (a)
            `UEI_OFS_EVT_CTS:
            begin
                r = {1'b1, 3'(`UEI_BIT_CTS)};
            end
            `UEI_OFS_EVT_CTS_LOST:
            begin
                r = {1'b1, 3'(`UEI_BIT_CTS_LOST)};
            end
            `UEI_OFS_EVT_RXD:
            begin
                r = {1'b1, 3'(`UEI_BIT_RXD)};
            end
            `UEI_OFS_EVT_TXD:
            begin
                r = {1'b1, 3'(`UEI_BIT_TXD)};
            end
            `UEI_OFS_EVT_ERR:
            begin
                r = {1'b1, 3'(`UEI_BIT_ERR)};
            end
            `UEI_OFS_EVT_RX_TMO:
            begin
                r = {1'b1, 3'(`UEI_BIT_RX_TMO)};
            end
            default:
            begin
                r = 4'h0;
            end
        endcase
        return r;
    endfunction

    // ----------------------------------------
    // bus phase decode
    // ----------------------------------------
    // never stalls: the read word is ready
    // from the setup cycle already
    assign pready = 1'b1;
    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign setup_rd = psel & ~penable & ~pwrite;
    assign {evt_sel, evt_idx} = evt_decode(12'(paddr));

    // known addresses
    always_comb
    begin
        mapped = evt_sel;
        if (12'(paddr) == `UEI_OFS_SHORTCUT
            || 12'(paddr) == `UEI_OFS_IRQ_SET
            || 12'(paddr) == `UEI_OFS_IRQ_CLR
            || 12'(paddr) == `UEI_OFS_STATUS)
        begin
            mapped = 1'b1;
        end
    end

    // unmapped access errors out, no effect
    assign pslverr = acc & ~mapped;

    // ----------------------------------------
    // flow-control edge detection
    // ----------------------------------------
    // idle level is high (not clear to send)
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cts_prev <= 1'b1;
        end
        else
        begin
            cts_prev <= cts_n;
        end
    end

    assign cts_fall = cts_prev & ~cts_n;
    assign cts_rise = ~cts_prev & cts_n;

    // collect all event pulses
    always_comb
    begin
        evt_hit = '0;
        evt_hit[`UEI_BIT_CTS] = cts_fall;
        evt_hit[`UEI_BIT_CTS_LOST] = cts_rise;
        evt_hit[`UEI_BIT_RXD] = evt_in.rx_byte;
        evt_hit[`UEI_BIT_TXD] = evt_in.tx_byte;
        evt_hit[`UEI_BIT_ERR] = evt_in.error;
        evt_hit[`UEI_BIT_RX_TMO] = evt_in.rx_timeout;
    end

    // ----------------------------------------
    // sticky event flags
    // ----------------------------------------
    // software clears by writing 0 to an
    // event register or 1 to the status
    // register; a new event in the same
    // cycle wins so nothing is lost
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            evt <= `UEI_RST_EVT;
        end
        else
        begin
            for (int i = 0; i < `UEI_NUM_EVT; i++)
            begin
                if (evt_hit[i])
                begin
                    // hardware set has priority
                    evt[i] <= 1'b1;
                end
                else if (wr && evt_sel
                         && evt_idx == 3'(i))
                begin
                    // plain register write
                    evt[i] <= pwdata[0];
                end
                else if (wr && 12'(paddr) == `UEI_OFS_STATUS
                         && pwdata[i])
                begin
                    // write one to clear
                    evt[i] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // shortcut register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shortcut <= `UEI_RST_SHORTCUT;
        end
        else if (wr && 12'(paddr) == `UEI_OFS_SHORTCUT)
        begin
            shortcut <= pwdata[1:0];
        end
    end

    // ----------------------------------------
    // interrupt enable, set and clear views
    // ----------------------------------------
    // only ones act; zero bits leave the
    // enable alone, so drivers can touch one
    // event without read-modify-write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            inten <= `UEI_RST_INTEN;
        end
        else if (wr && 12'(paddr) == `UEI_OFS_IRQ_SET)
        begin
            inten <= inten | pwdata[5:0];
        end
        else if (wr && 12'(paddr) == `UEI_OFS_IRQ_CLR)
        begin
            inten <= inten & ~pwdata[5:0];
        end
    end

    // ----------------------------------------
    // shortcut task pulses
    // ----------------------------------------
    // registered, so the task fires one cycle
    // after the edge that caused it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            task_out <= '0;
        end
        else
        begin
            task_out.start_rx <= cts_fall
                & shortcut[`UEI_BIT_SC_START];
            task_out.stop_rx <= cts_rise
                & shortcut[`UEI_BIT_SC_STOP];
        end
    end

    // ----------------------------------------
    // interrupt line
    // ----------------------------------------
    // level output straight from flag and mask
    assign irq = |(evt & inten);

    // ----------------------------------------
    // read data
    // ----------------------------------------
    // both enable views return the same state
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        if (evt_sel)
        begin
            next_prdata[0] = evt[evt_idx];
        end
        else if (12'(paddr) == `UEI_OFS_SHORTCUT)
        begin
            next_prdata[1:0] = shortcut;
        end
        else if (12'(paddr) == `UEI_OFS_IRQ_SET
                 || 12'(paddr) == `UEI_OFS_IRQ_CLR)
        begin
            next_prdata[5:0] = inten;
        end
        else if (12'(paddr) == `UEI_OFS_STATUS)
        begin
            next_prdata[5:0] = evt;
        end
    end

    // captured in the setup cycle so the
    // access phase sees a flopped word
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (setup_rd)
        begin
            prdata <= next_prdata;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // a bus write to a given address
    sequence s_wr_set;
        wr && 12'(paddr) == `UEI_OFS_IRQ_SET;
    endsequence

    sequence s_wr_clr;
        wr && 12'(paddr) == `UEI_OFS_IRQ_CLR;
    endsequence

    property p_start_short;
        @(posedge pclk) disable iff (!presetn)
        $fell(cts_n) && shortcut[0] |=> task_out.start_rx;
    endproperty
    a_start_short: assert property (p_start_short)
        else $error("start task missing");

    property p_no_start;
        @(posedge pclk) disable iff (!presetn)
        !shortcut[0] |=> !task_out.start_rx;
    endproperty
    a_no_start: assert property (p_no_start)
        else $error("start task without shortcut");

    property p_stop_short;
        @(posedge pclk) disable iff (!presetn)
        $rose(cts_n) && shortcut[1] |=> task_out.stop_rx;
    endproperty
    a_stop_short: assert property (p_stop_short)
        else $error("stop task missing");

    property p_set_view;
        @(posedge pclk) disable iff (!presetn)
        s_wr_set |=> (inten & $past(pwdata[5:0]))
            == $past(pwdata[5:0]);
    endproperty
    a_set_view: assert property (p_set_view)
        else $error("enable not set");

    property p_clr_view;
        @(posedge pclk) disable iff (!presetn)
        s_wr_clr |=> (inten & $past(pwdata[5:0])) == 6'h00;
    endproperty
    a_clr_view: assert property (p_clr_view)
        else $error("enable not cleared");

    property p_zero_write;
        @(posedge pclk) disable iff (!presetn)
        wr && pwdata[5:0] == 6'h00 && (12'(paddr) == `UEI_OFS_IRQ_SET
            || 12'(paddr) == `UEI_OFS_IRQ_CLR) |=> $stable(inten);
    endproperty
    a_zero_write: assert property (p_zero_write)
        else $error("zero write changed enables");

    property p_readback;
        @(posedge pclk) disable iff (!presetn)
        setup_rd && 12'(paddr) == `UEI_OFS_IRQ_CLR
            |=> prdata[5:0] == $past(inten);
    endproperty
    a_readback: assert property (p_readback)
        else $error("enable readback wrong");

    property p_cts_evt;
        @(posedge pclk) disable iff (!presetn)
        $fell(cts_n) |=> evt[`UEI_BIT_CTS];
    endproperty
    a_cts_evt: assert property (p_cts_evt)
        else $error("cts active event lost");

    property p_cts_lost_evt;
        @(posedge pclk) disable iff (!presetn)
        $rose(cts_n) |=> evt[`UEI_BIT_CTS_LOST];
    endproperty
    a_cts_lost_evt: assert property (p_cts_lost_evt)
        else $error("cts inactive event lost");

    property p_rxd_evt;
        @(posedge pclk) disable iff (!presetn)
        evt_in.rx_byte |=> evt[`UEI_BIT_RXD] ##1 irq
            || !inten[`UEI_BIT_RXD] || !evt[`UEI_BIT_RXD];
    endproperty
    a_rxd_evt: assert property (p_rxd_evt)
        else $error("byte received event lost");

    property p_irq_level;
        @(posedge pclk) disable iff (!presetn)
        evt_in.error && inten[`UEI_BIT_ERR]
            && !(wr && 12'(paddr) == `UEI_OFS_IRQ_CLR) |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("irq not raised");

endmodule

// >>> pkg/uei_map.svh
`ifndef UEI_MAP_SVH
`define UEI_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define UEI_OFS_EVT_CTS 12'h100
`define UEI_OFS_EVT_CTS_LOST 12'h104
`define UEI_OFS_EVT_RXD 12'h108
`define UEI_OFS_EVT_TXD 12'h11C
`define UEI_OFS_EVT_ERR 12'h124
`define UEI_OFS_EVT_RX_TMO 12'h144
`define UEI_OFS_SHORTCUT 12'h200
`define UEI_OFS_IRQ_SET 12'h304
`define UEI_OFS_IRQ_CLR 12'h308
`define UEI_OFS_STATUS 12'h310

// ----------------------------------------
// event bit positions (enable and status)
// ----------------------------------------
`define UEI_BIT_CTS 0
`define UEI_BIT_CTS_LOST 1
`define UEI_BIT_RXD 2
`define UEI_BIT_TXD 3
`define UEI_BIT_ERR 4
`define UEI_BIT_RX_TMO 5
`define UEI_NUM_EVT 6

// ----------------------------------------
// shortcut bit positions
// ----------------------------------------
`define UEI_BIT_SC_START 0
`define UEI_BIT_SC_STOP 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define UEI_RST_SHORTCUT 2'h0
`define UEI_RST_INTEN 6'h00
`define UEI_RST_EVT 6'h00

`endif

// >>> pkg/uei_pkg.sv
package uei_pkg;

    // ----------------------------------------
    // event inputs from the serial engine
    // ----------------------------------------
    typedef struct packed {
        logic rx_timeout; // receiver timed out
        logic error;      // line error seen
        logic tx_byte;    // byte left the shifter
        logic rx_byte;    // byte stored in holding reg
    } uei_evt_in_t;

    // ----------------------------------------
    // task pulses toward the receiver
    // ----------------------------------------
    typedef struct packed {
        logic stop_rx;  // stop receiver task
        logic start_rx; // start receiver task
    } uei_task_t;

    // event vector, one bit per event
    typedef logic [5:0] uei_vec_t;

endpackage

// >>> sim/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------
    // byte addresses and signals
    // ----------------------------------------
    localparam logic [11:0] A_SC = 12'h200;
    localparam logic [11:0] A_SET = 12'h304;
    localparam logic [11:0] A_CLR = 12'h308;
    localparam logic [11:0] A_STAT = 12'h310;
    localparam logic [11:0] A_BAD = 12'h0FC; // unmapped hole

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cts_n = 1'b1; // idle high, not clear to send
    uei_pkg::uei_evt_in_t evt_in = 4'h0;
    uei_pkg::uei_task_t task_out;
    logic irq;
    logic [7:0] n_rise;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    int n_start = 0; // cycles with start pulse high
    int n_stop = 0;
    logic last_err; // response of the last transfer

    uei_top uei_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cts_n(cts_n), .evt_in(evt_in), .task_out(task_out), .irq(irq));
    uei_irq_sink uei_irq_sink_inst (.pclk(pclk), .presetn(presetn), .irq(irq),
        .n_rise(n_rise));

    // clock and watchdog; ceiling far above the few hundred cycles needed
    always #50 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cyc = cyc + 1;
        if (task_out.start_rx === 1'b1)
            n_start = n_start + 1;
        if (task_out.stop_rx === 1'b1)
            n_stop = n_stop + 1;
        if (cyc == 5000)
        begin
            n_mismatch = n_mismatch + 1;
            close_out();
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; no wait-state count assumed, waits on pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        apb(1'b0, a, 32'h00000000, r);
        chk(r, exp);
    endtask

    // raise event i: 0 cts falls, 1 cts rises, 2..5 engine pulses
    task automatic fire(input int i);
        @(posedge pclk);
        if (i < 2)
            cts_n <= (i == 1);
        else
            evt_in <= 4'(1 << (i - 2));
        @(posedge pclk);
        evt_in <= 4'h0;
        repeat (3) @(posedge pclk);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // reset values, then walk each enable bit up and down through both views
    task automatic t_enables();
        logic [31:0] m;
        m = 32'h00000000;
        rd_chk(A_SC, 32'h00000000);
        rd_chk(A_SET, 32'h00000000);
        for (int i = 0; i < 6; i++)
        begin
            m = m | (32'h1 << i);
            wr(A_SET, 32'h1 << i);
            rd_chk(A_SET, m);
            rd_chk(A_CLR, m);
        end
        wr(A_SET, 32'h00000000);
        wr(A_CLR, 32'h00000000);
        rd_chk(A_SET, 32'h0000003F);
        for (int i = 0; i < 6; i++)
        begin
            m = m & ~(32'h1 << i);
            wr(A_CLR, 32'h1 << i);
            rd_chk(A_CLR, m);
            rd_chk(A_SET, m);
        end
    endtask

    // each event: flag while masked, irq once enabled, gone once cleared
    task automatic t_events();
        for (int i = 0; i < 6; i++)
        begin
            fire(i);
            chk(irq, 1'b0);
            rd_chk(A_STAT, 32'h1 << i);
            wr(A_SET, 32'h1 << i);
            @(posedge pclk);
            chk(irq, 1'b1);
            wr(A_STAT, 32'h1 << i);
            @(posedge pclk);
            chk(irq, 1'b0);
            wr(A_CLR, 32'h1 << i);
        end
        chk(n_rise, 8'h06);
        chk(n_start + n_stop, 0);
    endtask

    // shortcuts: one task pulse per cts edge only while the bit is one
    task automatic t_shortcuts();
        wr(A_SC, 32'h00000003);
        rd_chk(A_SC, 32'h00000003);
        fire(0);
        fire(1);
        chk(n_start, 1);
        chk(n_stop, 1);
        wr(A_SC, 32'h00000001);
        fire(0);
        fire(1);
        chk(n_start, 2);
        chk(n_stop, 1);
        chk(irq, 1'b0);
    endtask

    // per-event registers: flag reads back, zero write clears; enabled error raises irq
    task automatic t_evt_regs();
        rd_chk(12'h100, 32'h00000001);
        rd_chk(12'h104, 32'h00000001);
        wr(A_STAT, 32'h0000003F);
        wr(A_SET, 32'h00000010);
        fire(4);
        chk(irq, 1'b1);
        rd_chk(12'h124, 32'h00000001);
        wr(12'h124, 32'h00000000);
        @(posedge pclk);
        chk(irq, 1'b0);
        fire(2);
        rd_chk(12'h108, 32'h00000001);
        wr(12'h108, 32'h00000000);
        rd_chk(A_STAT, 32'h00000000);
        wr(A_CLR, 32'h00000010);
    endtask

    // unmapped address answers with an error and zero data
    task automatic t_unmapped();
        rd_chk(A_BAD, 32'h00000000);
        chk(last_err, 1'b1);
        rd_chk(A_SC, 32'h00000001);
        chk(last_err, 1'b0);
    endtask

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk(irq, 1'b0);
        t_enables();
        t_events();
        t_shortcuts();
        t_evt_regs();
        t_unmapped();
        close_out();
    end
endmodule

// >>> sim/uei_irq_sink.sv
// ----------------------------------------
// interrupt controller stand-in
// ----------------------------------------
module uei_irq_sink (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic irq,
    output logic [7:0] n_rise
);
    timeunit 1ns;
    timeprecision 1ns;

    logic irq_q; // last sampled level

    // count rising edges, as an edge-triggered interrupt controller sees new requests
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_q <= 1'b0;
            n_rise <= 8'h00;
        end
        else
        begin
            irq_q <= irq;
            if (irq && !irq_q)
                n_rise <= n_rise + 8'h01;
        end
    end
endmodule
